// ===== design/csit_top.sv
/*
  Clock select and interval timer: processor clock enable, sleep tick,
  detector override, capture and interval clocks, fixed timer and 12-bit
  reloading counter with interrupt, over APB.
  Assumes oscillator ticks and run flags are synchronous to mclk.
*/
// Behaviour
// RL1: Processor clock is the 24 MHz tick over a power-of-two divider.
// RL2: Speed 000,001,010,100,101,110 give 3,6,12,1.5,0.75,0.187 MHz; reset 000.
// RL3: Sleep codes 00 to 11 give a 512, 64, 8 or 1 Hz tick.
// RL4: No-buzz set keeps the reset detector on, clear lets duty gate it in sleep.
// RL5: Duty-cycle gating is independent of the sleep interval.
// RL6: Capture divider codes 00 to 11 divide by 2, 4, 6 or 8.
// RL7: Capture source 00 is 24 MHz, 10 is 32 kHz, 11 off, 01 reserved.
// RL8: Interval divider codes 00 to 11 divide by 1, 2, 3 or 4.
// RL9: Interval source 00 is 24 MHz, 10 is 32 kHz, 11 capture, 01 reserved.
// RL10: A source change applies only while old and new clocks run.
// RL11: Fixed timer counts 4096 capture ticks, 1024 us at 4 MHz.
// RL12: The 12-bit down counter reloads on the tick after zero.
// RL13: Each reload raises an interrupt.
// RL14: Software keeps reloads away from the two reload byte writes.
// RL15: Software rereads the counter until two readings agree on 32 kHz.
// RL16: Reserved speed or source codes leave the selection unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "csit_consts.svh"

module csit_top #(
  parameter int ADDR_WIDTH   = 12,
  parameter int DUTY_WIDTH   = 12,
  parameter int FIXED_COUNT  = `CSIT_FIXED_PERIOD_US * `CSIT_CAP_NOMINAL_MHZ
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  // Oscillator ticks and run flags
  input  wire logic                  fastOscTick,
  input  wire logic                  slowOscTick,
  input  wire logic                  fastOscRun,
  input  wire logic                  slowOscRun,
  // System status
  input  wire logic                  sleepActive,
  input  wire logic [1:0]            sleepDutySel,
  // Clock enables and status outputs
  output var  logic                  processorClkEn,
  output var  logic                  sleepTickEn,
  output var  logic                  porDetectEn,
  output var  logic                  captureClkEn,
  output var  logic                  intervalClkEn,
  output var  logic                  fixedTickEn,
  output var  logic                  irq
);
  import csit_pkg::*;

  // Reset images of the two 8-bit registers
  localparam logic [7:0] OSC_RST = `CSIT_RST_OSCILLATOR_CONTROL_0;
  localparam logic [7:0] TCC_RST = `CSIT_RST_TIMER_CLOCK_CONFIG;

  // Configuration registers
  csit_speed_type processorSpeed;
  csit_sel_type   sleepTimerSel;
  logic           noBuzz;
  csit_sel_type   captureDivSel;
  csit_sel_type   captureSrcReq;
  csit_sel_type   intervalDivSel;
  csit_sel_type   intervalSrcReq;
  csit_sel_type   captureSrc;
  csit_sel_type   intervalSrc;
  csit_count_type intervalReloadValue;
  csit_count_type intervalCounter;
  logic [1:0]     irqStatus;
  logic [1:0]     irqMask;

  // Bus decode
  logic [9:0]     regIndex;
  logic           access;
  logic           wrAccess;
  logic           rdAccess;
  logic           mapped;
  logic [31:0]    next_prdata;

  // Derived ticks and divisors
  logic [7:0]     speedDivisor;
  logic [15:0]    sleepDivisor;
  logic [3:0]     captureDivisor;
  logic [2:0]     intervalDivisor;
  logic           captureSrcTick;
  logic           intervalSrcTick;
  logic           captureRun;
  logic           reloadEvent;
  logic [DUTY_WIDTH-1:0] dutyCount;
  logic           dutyWindow;

  // Index of a register from its byte address
  function automatic logic [9:0] index_of(input logic [ADDR_WIDTH-1:0] addr);
    index_of = 10'(addr >> 2);
  endfunction

  // Whether a timer clock source code names a running clock
  function automatic logic source_runs(input csit_sel_type sel, input logic capRun);
    case (sel)
      `CSIT_SRC_FAST: source_runs = fastOscRun;
      `CSIT_SRC_SLOW: source_runs = slowOscRun;
      `CSIT_SRC_CAPT: source_runs = capRun;
      default:        source_runs = 1'b0;
    endcase
  endfunction

  // Tick of the selected oscillator, none for disabled or reserved codes
  function automatic logic source_tick(input csit_sel_type sel, input logic capTick);
    case (sel)
      `CSIT_SRC_FAST: source_tick = fastOscTick;
      `CSIT_SRC_SLOW: source_tick = slowOscTick;
      `CSIT_SRC_CAPT: source_tick = capTick;
      default:        source_tick = 1'b0;
    endcase
  endfunction

  // Decode of the current bus access
  assign regIndex = index_of(paddr);
  assign access   = psel && penable && pready;
  assign wrAccess = access && pwrite;
  assign rdAccess = access && !pwrite;
  assign mapped   = (regIndex == `CSIT_IDX_TIMER_CLOCK_CONFIG)
                 || (regIndex == `CSIT_IDX_OSCILLATOR_CONTROL_0)
                 || (regIndex == `CSIT_IDX_RELOAD)
                 || (regIndex == `CSIT_IDX_COUNTER)
                 || (regIndex == `CSIT_IDX_IRQ_STATUS)
                 || (regIndex == `CSIT_IDX_IRQ_MASK);

  // Read data multiplexer, reserved bits read zero
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (regIndex)
      `CSIT_IDX_TIMER_CLOCK_CONFIG:
        next_prdata[7:0] = {captureDivSel, captureSrcReq, intervalDivSel, intervalSrcReq};
      `CSIT_IDX_OSCILLATOR_CONTROL_0:
        next_prdata[7:0] = {2'h0, noBuzz, sleepTimerSel, processorSpeed};
      `CSIT_IDX_RELOAD:     next_prdata[11:0] = intervalReloadValue;
      `CSIT_IDX_COUNTER:    next_prdata[11:0] = intervalCounter;
      `CSIT_IDX_IRQ_STATUS: next_prdata[1:0]  = irqStatus;
      `CSIT_IDX_IRQ_MASK:   next_prdata[1:0]  = irqMask;
      default:              next_prdata = 32'h0000_0000;
    endcase
  end

  // APB answer: no wait state, ready in the first access cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  // Oscillator control register writes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      processorSpeed <= OSC_RST[`CSIT_SPEED_MSB:`CSIT_SPEED_LSB];
      sleepTimerSel  <= OSC_RST[`CSIT_SLEEP_MSB:`CSIT_SLEEP_LSB];
      noBuzz         <= OSC_RST[`CSIT_NOBUZZ_BIT];
    end else if (wrAccess && mapped && !pslverr && pstrb[0]
                 && regIndex == `CSIT_IDX_OSCILLATOR_CONTROL_0) begin
      sleepTimerSel <= pwdata[`CSIT_SLEEP_MSB:`CSIT_SLEEP_LSB];
      noBuzz        <= pwdata[`CSIT_NOBUZZ_BIT];
      // RL16: keep speed on reserved
      if (pwdata[`CSIT_SPEED_MSB:`CSIT_SPEED_LSB] != `CSIT_SPD_RSVD_A
          && pwdata[`CSIT_SPEED_MSB:`CSIT_SPEED_LSB] != `CSIT_SPD_RSVD_B) begin
        processorSpeed <= pwdata[`CSIT_SPEED_MSB:`CSIT_SPEED_LSB];
      end
    end
  end

  // Timer clock config register writes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      captureDivSel  <= TCC_RST[`CSIT_CDIV_MSB:`CSIT_CDIV_LSB];
      captureSrcReq  <= TCC_RST[`CSIT_CSEL_MSB:`CSIT_CSEL_LSB];
      intervalDivSel <= TCC_RST[`CSIT_IDIV_MSB:`CSIT_IDIV_LSB];
      intervalSrcReq <= TCC_RST[`CSIT_ISEL_MSB:`CSIT_ISEL_LSB];
    end else if (wrAccess && pstrb[0] && regIndex == `CSIT_IDX_TIMER_CLOCK_CONFIG) begin
      captureDivSel  <= pwdata[`CSIT_CDIV_MSB:`CSIT_CDIV_LSB];
      intervalDivSel <= pwdata[`CSIT_IDIV_MSB:`CSIT_IDIV_LSB];
      // RL16: reserved source ignored
      if (pwdata[`CSIT_CSEL_MSB:`CSIT_CSEL_LSB] != `CSIT_SRC_RSVD) begin
        captureSrcReq <= pwdata[`CSIT_CSEL_MSB:`CSIT_CSEL_LSB];
      end
      if (pwdata[`CSIT_ISEL_MSB:`CSIT_ISEL_LSB] != `CSIT_SRC_RSVD) begin
        intervalSrcReq <= pwdata[`CSIT_ISEL_MSB:`CSIT_ISEL_LSB];
      end
    end
  end

  // Capture clock runs while its selected oscillator runs
  assign captureRun = (captureSrc != `CSIT_SRC_CAPT) && source_runs(captureSrc, 1'b0);

  // Effective sources follow requests only while both clocks run
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      captureSrc  <= TCC_RST[`CSIT_CSEL_MSB:`CSIT_CSEL_LSB];
      intervalSrc <= TCC_RST[`CSIT_ISEL_MSB:`CSIT_ISEL_LSB];
    end else begin
      // RL10: capture switch needs both clocks
      if (captureSrcReq != captureSrc && captureRun
          && (captureSrcReq == `CSIT_SRC_CAPT || source_runs(captureSrcReq, 1'b0))) begin
        captureSrc <= captureSrcReq;
      end
      // RL10: interval switch needs both clocks
      if (intervalSrcReq != intervalSrc && source_runs(intervalSrc, captureRun)
          && source_runs(intervalSrcReq, captureRun)) begin
        intervalSrc <= intervalSrcReq;
      end
    end
  end

  // RL2: speed code to divisor
  always_comb begin
    case (processorSpeed)
      3'h0:    speedDivisor = `CSIT_DIV_SPD0;
      3'h1:    speedDivisor = `CSIT_DIV_SPD1;
      3'h2:    speedDivisor = `CSIT_DIV_SPD2;
      3'h4:    speedDivisor = `CSIT_DIV_SPD4;
      3'h5:    speedDivisor = `CSIT_DIV_SPD5;
      3'h6:    speedDivisor = `CSIT_DIV_SPD6;
      default: speedDivisor = `CSIT_DIV_SPD0;
    endcase
  end

  // RL3: sleep code to divisor
  always_comb begin
    case (sleepTimerSel)
      2'h0:    sleepDivisor = `CSIT_DIV_SLP0;
      2'h1:    sleepDivisor = `CSIT_DIV_SLP1;
      2'h2:    sleepDivisor = `CSIT_DIV_SLP2;
      default: sleepDivisor = `CSIT_DIV_SLP3;
    endcase
  end

  // RL6: capture divisor 2, 4, 6, 8
  assign captureDivisor  = {1'b0, captureDivSel, 1'b0} + 4'h2;
  // RL8: interval divisor 1 to 4
  assign intervalDivisor = {1'b0, intervalDivSel} + 3'h1;

  // RL7: capture source tick, none when disabled
  assign captureSrcTick  = (captureSrc == `CSIT_SRC_CAPT) ? 1'b0
                         : source_tick(captureSrc, 1'b0);
  // RL9: interval source tick
  assign intervalSrcTick = source_tick(intervalSrc, captureClkEn);

  // RL1: processor clock from fast oscillator
  csit_divider #(.WIDTH(8)) uSpeedDiv (
    .clk     (mclk),
    .arst_n  (arst_n),
    .clear   (1'b0),
    .divisor (speedDivisor),
    .tickIn  (fastOscTick),
    .tickOut (processorClkEn)
  );

  // Sleep timer tick from slow oscillator
  csit_divider #(.WIDTH(16)) uSleepDiv (
    .clk     (mclk),
    .arst_n  (arst_n),
    .clear   (1'b0),
    .divisor (sleepDivisor),
    .tickIn  (slowOscTick),
    .tickOut (sleepTickEn)
  );

  // Capture clock prescaler
  csit_divider #(.WIDTH(4)) uCaptureDiv (
    .clk     (mclk),
    .arst_n  (arst_n),
    .clear   (1'b0),
    .divisor (captureDivisor),
    .tickIn  (captureSrcTick),
    .tickOut (captureClkEn)
  );

  // Interval clock prescaler
  csit_divider #(.WIDTH(3)) uIntervalDiv (
    .clk     (mclk),
    .arst_n  (arst_n),
    .clear   (1'b0),
    .divisor (intervalDivisor),
    .tickIn  (intervalSrcTick),
    .tickOut (intervalClkEn)
  );

  // RL11: fixed timer from capture clock
  csit_divider #(.WIDTH(13)) uFixedDiv (
    .clk     (mclk),
    .arst_n  (arst_n),
    .clear   (1'b0),
    .divisor (13'(FIXED_COUNT)),
    .tickIn  (captureClkEn),
    .tickOut (fixedTickEn)
  );

  // RL5: free-running duty counter on slow oscillator
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dutyCount <= '0;
    end else if (slowOscTick) begin
      dutyCount <= dutyCount + DUTY_WIDTH'(1);
    end
  end

  // Duty window: one slow tick in 2^(6+2*sel)
  always_comb begin
    case (sleepDutySel)
      2'h0:    dutyWindow = (dutyCount[5:0] == 6'h00);
      2'h1:    dutyWindow = (dutyCount[7:0] == 8'h00);
      2'h2:    dutyWindow = (dutyCount[9:0] == 10'h000);
      default: dutyWindow = (dutyCount[11:0] == 12'h000);
    endcase
  end

  // RL4: no-buzz forces detector on
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      porDetectEn <= 1'b1;
    end else begin
      porDetectEn <= noBuzz || !sleepActive || dutyWindow;
    end
  end

  // RL14: reload bytes written per lane
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      intervalReloadValue <= `CSIT_RST_RELOAD;
    end else if (wrAccess && regIndex == `CSIT_IDX_RELOAD) begin
      if (pstrb[0]) begin
        intervalReloadValue[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        intervalReloadValue[11:8] <= pwdata[11:8];
      end
    end
  end

  // RL12: down counter reloads on the tick after zero
  assign reloadEvent = intervalClkEn && (intervalCounter == 12'h000);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      intervalCounter <= `CSIT_RST_RELOAD;
    end else if (reloadEvent) begin
      intervalCounter <= intervalReloadValue;
    end else if (intervalClkEn) begin
      intervalCounter <= intervalCounter - 12'h001;
    end
  end

  // Interrupt mask register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irqMask <= `CSIT_RST_MASK;
    end else if (wrAccess && pstrb[0] && regIndex == `CSIT_IDX_IRQ_MASK) begin
      irqMask <= pwdata[1:0];
    end
  end

  // RL13: sticky status, read clears, set wins
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irqStatus <= 2'h0;
    end else begin
      if (rdAccess && regIndex == `CSIT_IDX_IRQ_STATUS) begin
        irqStatus <= 2'h0;
      end
      if (reloadEvent) begin
        irqStatus[`CSIT_IRQ_RELOAD] <= 1'b1;
      end
      if (fixedTickEn) begin
        irqStatus[`CSIT_IRQ_FIXED] <= 1'b1;
      end
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

endmodule

`default_nettype wire

// ===== design/csit_consts.svh
/*
  Indices, fields, reset values and divisors of the timer block.
  Assumes inclusion by bare name.
*/
`ifndef CSIT_CONSTS_SVH
`define CSIT_CONSTS_SVH

// Register indices (byte address is four times the index)
`define CSIT_IDX_TIMER_CLOCK_CONFIG   10'h031
`define CSIT_IDX_OSCILLATOR_CONTROL_0 10'h1E0
`define CSIT_IDX_RELOAD               10'h040
`define CSIT_IDX_COUNTER              10'h041
`define CSIT_IDX_IRQ_STATUS           10'h042
`define CSIT_IDX_IRQ_MASK             10'h043

// Reset values
`define CSIT_RST_TIMER_CLOCK_CONFIG   8'h8F
`define CSIT_RST_OSCILLATOR_CONTROL_0 8'h08
`define CSIT_RST_RELOAD               12'hFFF
`define CSIT_RST_MASK                 2'h0

// Field positions of oscillator_control_0
`define CSIT_SPEED_LSB   0
`define CSIT_SPEED_MSB   2
`define CSIT_SLEEP_LSB   3
`define CSIT_SLEEP_MSB   4
`define CSIT_NOBUZZ_BIT  5

// Field positions of timer_clock_config
`define CSIT_ISEL_LSB    0
`define CSIT_ISEL_MSB    1
`define CSIT_IDIV_LSB    2
`define CSIT_IDIV_MSB    3
`define CSIT_CSEL_LSB    4
`define CSIT_CSEL_MSB    5
`define CSIT_CDIV_LSB    6
`define CSIT_CDIV_MSB    7

// Source codes of the two timer clock select fields
`define CSIT_SRC_FAST    2'h0
`define CSIT_SRC_RSVD    2'h1
`define CSIT_SRC_SLOW    2'h2
`define CSIT_SRC_CAPT    2'h3

// Processor speed codes and the 24 MHz divisors they pick
`define CSIT_SPD_RSVD_A  3'h3
`define CSIT_SPD_RSVD_B  3'h7
`define CSIT_DIV_SPD0    8'h08
`define CSIT_DIV_SPD1    8'h04
`define CSIT_DIV_SPD2    8'h02
`define CSIT_DIV_SPD4    8'h10
`define CSIT_DIV_SPD5    8'h20
`define CSIT_DIV_SPD6    8'h80

// Sleep timer divisors of the 32768 Hz oscillator (512, 64, 8, 1 Hz)
`define CSIT_DIV_SLP0    16'h0040
`define CSIT_DIV_SLP1    16'h0200
`define CSIT_DIV_SLP2    16'h1000
`define CSIT_DIV_SLP3    16'h8000

// Fixed interval timer: 1024 us at a nominal 4 MHz capture clock
`define CSIT_FIXED_PERIOD_US 1024
`define CSIT_CAP_NOMINAL_MHZ 4

// Interrupt status bits
`define CSIT_IRQ_RELOAD  0
`define CSIT_IRQ_FIXED   1

`endif

// ===== design/csit_pkg.sv
/*
  Types of the timer block.
  Assumes nothing.
*/
package csit_pkg;
  typedef logic [1:0]  csit_sel_type;
  typedef logic [2:0]  csit_speed_type;
  typedef logic [11:0] csit_count_type;
endpackage

// ===== design/csit_divider.sv
/*
  Enable divider: one pulse per divisor input ticks.
  Assumes tickIn is a one-cycle enable on clk.
*/
`timescale 1ns/1ps
`default_nettype none

module csit_divider #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Control
  input  wire logic             clear,
  input  wire logic [WIDTH-1:0] divisor,
  input  wire logic             tickIn,
  // Divided enable
  output var  logic             tickOut
);

  logic [WIDTH-1:0] count;

  // Count input ticks, emit a pulse in the cycle after the last of each group
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count   <= '0;
      tickOut <= 1'b0;
    end else if (clear) begin
      count   <= '0;
      tickOut <= 1'b0;
    end else begin
      tickOut <= 1'b0;
      if (tickIn) begin
        if (count >= divisor - WIDTH'(1)) begin
          count   <= '0;
          tickOut <= 1'b1;
        end else begin
          count <= count + WIDTH'(1);
        end
      end
    end
  end

endmodule

`default_nettype wire

// ===== tb/csit_top_chk.sv
/*
  Checker of APB timing, enable pulse causes and detector override.
  Assumes binding to csit_top, ports only.
*/
`timescale 1ns/1ps
`default_nettype none
`include "csit_consts.svh"

module csit_top_chk #(
  parameter int ADDR_WIDTH  = 12,
  parameter int DUTY_WIDTH  = 12,
  parameter int FIXED_COUNT = 4096
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  // APB
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  input  wire logic [31:0]           prdata,
  input  wire logic                  pready,
  input  wire logic                  pslverr,
  // Oscillator ticks
  input  wire logic                  fastOscTick,
  input  wire logic                  slowOscTick,
  // Enables
  input  wire logic                  processorClkEn,
  input  wire logic                  sleepTickEn,
  input  wire logic                  porDetectEn,
  input  wire logic                  captureClkEn,
  input  wire logic                  intervalClkEn,
  input  wire logic                  fixedTickEn
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  logic noBuzz;

  // Shadow of the no-buzz bit, taken from completed writes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      noBuzz <= 1'b0;
    end else if (psel && penable && pready && pwrite && pstrb[0]
                 && paddr[ADDR_WIDTH-1:2] == `CSIT_IDX_OSCILLATOR_CONTROL_0) begin
      noBuzz <= pwdata[`CSIT_NOBUZZ_BIT];
    end
  end

  // Bus phases
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence

  property p_ready;
    s_setup |=> s_answer;
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  property p_rdata;
    !(psel && penable && !pwrite) |-> prdata == 32'h0;
  endproperty
  property p_cpu;
    processorClkEn |-> $past(fastOscTick);
  endproperty
  property p_cpuGap;
    processorClkEn |=> !processorClkEn;
  endproperty
  property p_sleep;
    sleepTickEn |-> $past(slowOscTick);
  endproperty
  property p_noBuzz;
    noBuzz && $past(noBuzz) |-> porDetectEn;
  endproperty
  property p_capGap;
    captureClkEn |=> !captureClkEn;
  endproperty
  property p_capSrc;
    captureClkEn |-> $past(fastOscTick || slowOscTick);
  endproperty
  property p_intSrc;
    intervalClkEn |-> $past(fastOscTick || slowOscTick || captureClkEn);
  endproperty
  property p_fixed;
    fixedTickEn |-> $past(captureClkEn);
  endproperty

  a_ready: assert property (p_ready)
    else $error("pready timing");
  a_err: assert property (p_err)
    else $error("pslverr alone");
  a_rdata: assert property (p_rdata)
    else $error("stray prdata");
  a_cpu: assert property (p_cpu)
    else $error("cpu tick cause");
  a_cpuGap: assert property (p_cpuGap)
    else $error("cpu tick gap");
  a_sleep: assert property (p_sleep)
    else $error("sleep tick cause");
  a_noBuzz: assert property (p_noBuzz)
    else $error("detector off");
  a_capGap: assert property (p_capGap)
    else $error("capture gap");
  a_capSrc: assert property (p_capSrc)
    else $error("capture cause");
  a_intSrc: assert property (p_intSrc)
    else $error("interval cause");
  a_fixed: assert property (p_fixed)
    else $error("fixed cause");
endmodule

bind csit_top csit_top_chk #(
  .ADDR_WIDTH(ADDR_WIDTH), .DUTY_WIDTH(DUTY_WIDTH), .FIXED_COUNT(FIXED_COUNT)
) chk_u (
  .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .fastOscTick(fastOscTick), .slowOscTick(slowOscTick),
  .processorClkEn(processorClkEn), .sleepTickEn(sleepTickEn),
  .porDetectEn(porDetectEn), .captureClkEn(captureClkEn),
  .intervalClkEn(intervalClkEn), .fixedTickEn(fixedTickEn)
);
`default_nettype wire

// ===== tb/csit_top_tb_top.sv
/*
  Bench of the clock select and interval timer.
  Assumes package, header and checker compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module csit_top_tb_top;
  import csit_pkg::*;
  logic        mclk, arst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [3:0]  pstrb;
  logic        fastOscTick, slowOscTick, fastOscRun, slowOscRun, sleepActive;
  logic [1:0]  sleepDutySel;
  logic        processorClkEn, sleepTickEn, porDetectEn, captureClkEn;
  logic        intervalClkEn, fixedTickEn, fastOn, irqPrev;
  logic [33:0] expQ[$];
  logic [33:0] e;
  int          failCount, cmpCount, cyc, riseCnt, riseAt, porLow, capCnt, p, t1, c0, cur;
  int          spdDiv[8] = '{8, 4, 2, 0, 16, 32, 128, 0};

  csit_top #(.FIXED_COUNT(8)) dut_u (
    .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fastOscTick(fastOscTick), .slowOscTick(slowOscTick),
    .fastOscRun(fastOscRun), .slowOscRun(slowOscRun), .sleepActive(sleepActive),
    .sleepDutySel(sleepDutySel), .processorClkEn(processorClkEn),
    .sleepTickEn(sleepTickEn), .porDetectEn(porDetectEn), .captureClkEn(captureClkEn),
    .intervalClkEn(intervalClkEn), .fixedTickEn(fixedTickEn), .irq(irq)
  );

  // Clock
  always #5 mclk = ~mclk;

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  function automatic logic sig(input int s);
    case (s)
      0: return processorClkEn;
      1: return sleepTickEn;
      2: return captureClkEn;
      3: return intervalClkEn;
      default: return fixedTickEn;
    endcase
  endfunction

  // Oscillator ticks, random status inputs, event counters
  always @(posedge mclk) begin
    rnd <= xs(rnd);
    sleepActive <= rnd[0];
    sleepDutySel <= rnd[2:1];
    fastOscTick <= fastOn;
    slowOscTick <= slowOscRun & ~slowOscTick;
    cyc <= cyc + 1;
    irqPrev <= irq;
    if (irq && !irqPrev) begin
      riseCnt <= riseCnt + 1;
      riseAt <= cyc;
    end
    if (!porDetectEn) porLow <= porLow + 1;
    if (captureClkEn || fixedTickEn) capCnt <= capCnt + 1;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      failCount++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic timeout;
    failCount++;
    summarize;
  endtask

  // Read monitor takes the oldest expectation
  always @(posedge mclk) begin
    if (arst_n && psel && penable && pready && !pwrite) begin
      e = (expQ.size() > 0) ? expQ.pop_front() : 34'h3FFFFFFFF;
      check("pslverr", 32'(pslverr), 32'(e[32]));
      if (e[33]) check("prdata", prdata, e[31:0]);
    end
  end

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                     input logic [3:0] st);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    pstrb <= st;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (!pready && n < 20);
    if (n >= 20) timeout;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [3:0] st = 4'hF);
    apb(1'b1, idx, d, st);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] d, input logic er = 1'b0,
                    input logic care = 1'b1);
    expQ.push_back({care, er, d});
    apb(1'b0, idx, 32'h0, 4'h0);
  endtask

  // Cycles between pulses, gap after the second pulse kept
  task automatic period(input int s);
    for (int k = 0; k < 3; k++) begin
      p = 0;
      do begin
        @(posedge mclk);
        p++;
      end while (!sig(s) && p < 20000);
    end
    if (p >= 20000) timeout;
  endtask

  task automatic waitRise;
    int r0;
    int n;
    r0 = riseCnt;
    n = 0;
    while (riseCnt == r0) begin
      @(posedge mclk);
      n++;
      if (n > 10000) timeout;
    end
  endtask

  // Main sequence
  initial begin
    {mclk, arst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {fastOscTick, slowOscTick, slowOscRun, sleepActive, sleepDutySel, fastOn, irqPrev} = '0;
    fastOscRun = 1'b1;
    rnd = 32'hB923;
    {failCount, cmpCount, cyc, riseCnt, riseAt, porLow, capCnt, cur} = '0;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    rd(10'h031, 32'h8F);
    rd(10'h1E0, 32'h08);
    rd(10'h040, 32'hFFF);
    rd(10'h041, 32'hFFF);
    rd(10'h042, 32'h0);
    rd(10'h043, 32'h0);
    rd(10'h100, 32'h0, 1'b1);
    fastOn <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(10'h1E0, {rnd[31:6], 3'b000, 3'(c)});
      if (spdDiv[c] != 0) cur = c;
      rd(10'h1E0, 32'(cur));
      if (spdDiv[c] != 0) begin
        period(0);
        check("cpuPeriod", 32'(p), 32'(spdDiv[c]));
      end
    end
    slowOscRun <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(10'h1E0, 32'h20 | (32'(s) << 3));
      rd(10'h1E0, 32'h20 | (32'(s) << 3));
      c0 = porLow;
      if (s < 2) begin
        period(1);
        check("sleepPeriod", 32'(p), 32'(128 << (3 * s)));
      end
      check("porLow", 32'(porLow - c0), 32'h0);
    end
    for (int c = 0; c < 4; c++) begin
      wr(10'h031, 32'(c) << 6);
      period(2);
      check("capPeriod", 32'(p), 32'(2 * c + 2));
      period(4);
      check("fixedPeriod", 32'(p), 32'(16 * c + 16));
    end
    wr(10'h031, 32'hC1);
    rd(10'h031, 32'hC0);
    for (int i = 0; i < 4; i++) begin
      wr(10'h031, 32'(i) << 2);
      period(3);
      check("intPeriod", 32'(p), 32'(i + 1));
    end
    wr(10'h031, 32'h47);
    period(3);
    check("intCapPeriod", 32'(p), 32'h8);
    wr(10'h031, 32'h00);
    slowOscRun <= 1'b0;
    wr(10'h031, 32'h0E);
    rd(10'h031, 32'h0E);
    period(3);
    check("intHeld", 32'(p), 32'h4);
    slowOscRun <= 1'b1;
    period(3);
    check("intSlow", 32'(p), 32'h8);
    wr(10'h031, 32'h32);
    rd(10'h031, 32'h32);
    c0 = capCnt;
    repeat (100) @(posedge mclk);
    check("capOff", 32'(capCnt - c0), 32'h0);
    // reload bytes written with the interval clock stopped
    slowOscRun <= 1'b0;
    wr(10'h040, 32'h0, 4'h1);
    wr(10'h040, 32'h100, 4'h2);
    rd(10'h040, 32'h100);
    wr(10'h043, 32'h1);
    rd(10'h042, 32'h0, 1'b0, 1'b0);
    slowOscRun <= 1'b1;
    waitRise;
    t1 = riseAt;
    rd(10'h042, 32'h1);
    waitRise;
    check("reloadPeriod", 32'(riseAt - t1), 32'd514);
    wr(10'h043, 32'h0);
    rd(10'h042, 32'h0, 1'b0, 1'b0);
    repeat (600) @(posedge mclk);
    check("irqMasked", 32'(irq), 32'h0);
    rd(10'h042, 32'h1);
    summarize;
  end
endmodule
`default_nettype wire
